// *** logic/table_reader.sv ***
/*
 table read block: 12-bit pointer registers and a trigger register that
 fetches a program rom byte into the working register and itself.
 assumes a single-cycle register port whose read data follow a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "table_read_params.svh"
// Overview of operation
// - pointer low register, read/write, bits seven to zero, resets to zero.
// - pointer high register, low four bits hold pointer bits eleven to eight.
// - writing 01h fetches rom low byte into working and trigger registers.
// - writing 02h fetches rom high byte into working and trigger registers.
// - after a fetch, reading the trigger register returns the fetched byte.
module table_reader (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`TRD_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [7:0] work_data,
    output logic work_load,
    output logic fetch_busy
);
    logic [7:0] ptr_low_r;
    logic [3:0] ptr_high_r;
    logic [7:0] trigger_r;
    logic [7:0] work_r;
    logic work_load_r;
    logic high_sel_r;
    logic [7:0] rdata_r;
    table_read_pkg::fetch_state_t state_r;
    table_read_pkg::fetch_state_t state_nxt;

    wire sel_low = (addr == `TRD_OFS_PTR_LOW);
    wire sel_high = (addr == `TRD_OFS_PTR_HIGH);
    wire sel_trig = (addr == `TRD_OFS_TRIGGER);
    wire wr_low = wr && sel_low;
    wire wr_high = wr && sel_high;
    wire wr_trig = wr && sel_trig;
    // other codes are illegal; ignoring them keeps the trigger stable
    wire cmd_low = wr_trig && (wdata == `TRD_CMD_LOW);
    wire cmd_high = wr_trig && (wdata == `TRD_CMD_HIGH);
    wire cmd_go = (cmd_low || cmd_high) && (state_r == table_read_pkg::ST_IDLE);
    wire [`TRD_ROM_AW-1:0] rom_addr = {ptr_high_r, ptr_low_r};
    wire [`TRD_ROM_DW-1:0] rom_word;
    wire [7:0] rom_byte = high_sel_r ? rom_word[15:8] : rom_word[7:0];
    wire [7:0] rd_mux = sel_low ? ptr_low_r :
                        sel_high ? {4'h0, ptr_high_r} :
                        sel_trig ? trigger_r : 8'h00;

    prog_rom #(
        .AW(`TRD_ROM_AW),
        .DW(`TRD_ROM_DW)
    ) u_rom (
        .clk(clk),
        .rd_en(cmd_go),
        .addr(rom_addr),
        .rd_data(rom_word)
    );

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            table_read_pkg::ST_IDLE:
            begin
                // a second command only starts from idle, so one fetch at a time
                if (cmd_go)
                    state_nxt = table_read_pkg::ST_WAIT;
            end
            table_read_pkg::ST_WAIT:
            begin
                // rom word is in its output register now
                state_nxt = table_read_pkg::ST_DONE;
            end
            table_read_pkg::ST_DONE:
            begin
                // one spare cycle keeps the load pulse apart from the next command
                state_nxt = table_read_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = table_read_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ptr_low_r <= `TRD_RST_PTR_LOW;
            ptr_high_r <= `TRD_RST_PTR_HIGH;
            state_r <= table_read_pkg::ST_IDLE;
            high_sel_r <= 1'b0;
        end
        else
        begin
            if (wr_low)
                ptr_low_r <= wdata;
            if (wr_high)
                ptr_high_r <= wdata[3:0];
            state_r <= state_nxt;
            if (cmd_go)
                high_sel_r <= cmd_high;
        end
    end

    // fetched byte lands in both places one cycle after the rom read
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            trigger_r <= `TRD_RST_TRIGGER;
            work_r <= 8'h00;
            work_load_r <= 1'b0;
        end
        else
        begin
            work_load_r <= (state_r == table_read_pkg::ST_WAIT);
            if (state_r == table_read_pkg::ST_WAIT)
            begin
                trigger_r <= rom_byte;
                work_r <= rom_byte;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_r <= 8'h00;
        else if (rd)
            rdata_r <= rd_mux;
    end

    assign rdata = rdata_r;
    assign work_data = work_r;
    assign work_load = work_load_r;
    assign fetch_busy = (state_r != table_read_pkg::ST_IDLE);

    ptr_reset_a: assert property (@(posedge clk) !rst_n |=> ptr_low_r == 8'h00 && ptr_high_r == 4'h0)
        else $error("pointer not cleared by reset");
    ptr_low_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_low |=> ptr_low_r == $past(wdata))
        else $error("pointer low write lost");
    ptr_high_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_high |=> ptr_high_r == $past(wdata[3:0]))
        else $error("pointer high write lost");
    fetch_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go && cmd_low |=> ##1 trigger_r == rom_word[7:0] && work_r == rom_word[7:0])
        else $error("low byte fetch wrong");
    fetch_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go && cmd_high |=> ##1 trigger_r == rom_word[15:8] && work_r == rom_word[15:8])
        else $error("high byte fetch wrong");
    trig_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && sel_trig |=> rdata == $past(trigger_r))
        else $error("trigger readback wrong");
    rom_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        rom_addr[11:8] == ptr_high_r && rom_addr[7:0] == ptr_low_r)
        else $error("rom address malformed");
    load_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go |=> !work_load ##1 work_load ##1 !work_load)
        else $error("work load timing wrong");

    // busy covers the rom read and the load cycle, then drops
    busy_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go |=> fetch_busy ##1 fetch_busy ##1 !fetch_busy)
        else $error("busy window wrong");

    // a command while busy must not restart the fetch
    busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_trig && fetch_busy |=> state_r != table_read_pkg::ST_WAIT)
        else $error("command taken while busy");

    // an illegal code leaves the block idle and the trigger untouched
    bad_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_trig && !cmd_low && !cmd_high && !fetch_busy
        |=> !fetch_busy && $stable(trigger_r))
        else $error("illegal code acted on");

    trig_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_r != table_read_pkg::ST_WAIT |=> $stable(trigger_r))
        else $error("trigger changed without fetch");

    work_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_r != table_read_pkg::ST_WAIT |=> $stable(work_data))
        else $error("working register changed without fetch");

    ptr_low_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_low |=> $stable(ptr_low_r))
        else $error("pointer low changed without write");

    ptr_high_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_high |=> $stable(ptr_high_r))
        else $error("pointer high changed without write");

    // read data hold between reads, so a slow reader still sees them
    rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> $stable(rdata))
        else $error("read data changed without read");

    low_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && sel_low |=> rdata == $past(ptr_low_r))
        else $error("pointer low readback wrong");

    high_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && sel_high |=> rdata == {4'h0, $past(ptr_high_r)})
        else $error("pointer high readback wrong");

    unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && !sel_low && !sel_high && !sel_trig |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // both copies of the fetched byte agree when the load pulse shows
    copies_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        work_load |-> work_data == trigger_r)
        else $error("working and trigger copies differ");

    fetch_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go |=> state_r == table_read_pkg::ST_WAIT)
        else $error("fetch did not start");

    byte_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go |=> high_sel_r == $past(cmd_high))
        else $error("byte select not latched");
endmodule : table_reader
`default_nettype wire

// *** logic/table_read_params.svh ***
/*
 constants for the table read block: register offsets, reset values,
 command codes and widths. assumes nothing of its surroundings.
*/
`ifndef TABLE_READ_PARAMS_SVH
`define TABLE_READ_PARAMS_SVH
`define TRD_OFS_PTR_LOW 9'h185
`define TRD_OFS_PTR_HIGH 9'h186
`define TRD_OFS_TRIGGER 9'h18C
`define TRD_RST_PTR_LOW 8'h00
`define TRD_RST_PTR_HIGH 4'h0
`define TRD_RST_TRIGGER 8'h00
`define TRD_CMD_LOW 8'h01
`define TRD_CMD_HIGH 8'h02
`define TRD_ADDR_W 9
`define TRD_ROM_AW 12
`define TRD_ROM_DW 16
`endif

// *** logic/table_read_pkg.sv ***
/*
 types for the table read block.
 assumes the params header is compiled alongside.
*/
package table_read_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } fetch_state_t;
endpackage : table_read_pkg

// *** logic/prog_rom.sv ***
/*
 program rom model: synchronous read, data out of a register.
 assumes contents are given by the deterministic fill in the initial block.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_rom #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // plain deterministic contents so the image is defined without a file
    initial
    begin
        for (int i = 0; i < (1 << AW); i++)
            mem[i] = DW'(i * 257 + 16'h5A);
    end

    always_ff @(posedge clk)
    begin
        if (rd_en)
            rd_data <= mem[addr];
    end
endmodule : prog_rom
`default_nettype wire

// *** testbench/fw_master.sv ***
/*
 firmware model: register port master, one access per task call.
 assumes clk comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module fw_master (
    input wire logic clk,
    output logic [8:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial
    begin
        addr = 9'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // single caller context, so fetches never interleave
    task automatic put(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask : put
    task automatic get(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : get
endmodule : fw_master
`default_nettype wire

// *** testbench/table_reader_tb.sv ***
/*
 bench for the table reader: reset values, fetch rows, then odd cases and a mid reset.
 assumes the rom fill word[i] = i*257+5Ah.
*/
`timescale 1ns/1ps
`default_nettype none
`include "table_read_params.svh"
module table_reader_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] addr;
    logic [7:0] wdata, rdata, work_data, v;
    logic wr, rd, work_load, fetch_busy;
    int bad_count = 0;
    int check_count = 0;
    typedef struct {logic [11:0] p; logic [7:0] c;} row_t;
    row_t rows [6] = '{'{12'h000, 8'h01}, '{12'h000, 8'h02}, '{12'hFFF, 8'h01},
        '{12'hFFF, 8'h02}, '{12'h5A3, 8'h02}, '{12'hA5C, 8'h01}};
    always #20 clk = ~clk;
    table_reader table_reader_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .work_data(work_data), .work_load(work_load),
        .fetch_busy(fetch_busy));
    fw_master fw_master_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic fetch(input logic [11:0] p, input logic [7:0] c);
        logic [15:0] w;
        int n;
        w = 16'(p * 257 + 16'h5A);
        fw_master_inst.put(`TRD_OFS_PTR_LOW, p[7:0]);
        fw_master_inst.put(`TRD_OFS_PTR_HIGH, {4'h0, p[11:8]});
        fw_master_inst.put(`TRD_OFS_TRIGGER, c);
        for (n = 0; n < 8 && work_load !== 1'b1; n++)
            @(posedge clk) #1;
        if (n == 8)
        begin
            bad_count++;
            tally_and_finish();
        end
        chk("work", work_data, c[1] ? w[15:8] : w[7:0]);
        chk("busy", {7'h00, fetch_busy}, 8'h01);
        fw_master_inst.get(`TRD_OFS_TRIGGER, v);
        chk("trigger", v, c[1] ? w[15:8] : w[7:0]);
        chk("idle", {7'h00, fetch_busy}, 8'h00);
    endtask : fetch
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        fw_master_inst.get(`TRD_OFS_PTR_LOW, v);
        chk("ptr_low", v, `TRD_RST_PTR_LOW);
        fw_master_inst.get(`TRD_OFS_PTR_HIGH, v);
        chk("ptr_high", v, 8'h00);
        fw_master_inst.get(`TRD_OFS_TRIGGER, v);
        chk("trigger", v, `TRD_RST_TRIGGER);
        $display("test reset done");
        foreach (rows[i])
            fetch(rows[i].p, rows[i].c);
        $display("test fetch rows done");
        fw_master_inst.put(`TRD_OFS_PTR_HIGH, 8'hFF);
        fw_master_inst.get(`TRD_OFS_PTR_HIGH, v);
        chk("ptr_high", v, 8'h0F);
        fw_master_inst.put(`TRD_OFS_PTR_LOW, 8'hA5);
        fw_master_inst.get(`TRD_OFS_PTR_LOW, v);
        chk("ptr_low", v, 8'hA5);
        // bad command must leave the last fetched byte in place
        fw_master_inst.put(`TRD_OFS_TRIGGER, 8'h03);
        repeat (4) @(posedge clk);
        fw_master_inst.get(`TRD_OFS_TRIGGER, v);
        chk("refused", v, 8'hB6);
        fw_master_inst.get(9'h187, v);
        chk("unmapped", v, 8'h00);
        // pointer is FA5 here: word B4FF; the high command lands while busy
        fw_master_inst.put(`TRD_OFS_TRIGGER, `TRD_CMD_LOW);
        fw_master_inst.put(`TRD_OFS_TRIGGER, `TRD_CMD_HIGH);
        repeat (4) @(posedge clk);
        fw_master_inst.get(`TRD_OFS_TRIGGER, v);
        chk("busy_refused", v, 8'hFF);
        chk("busy_work", work_data, 8'hFF);
        $display("test awkward done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        fw_master_inst.get(`TRD_OFS_PTR_LOW, v);
        chk("ptr_low", v, `TRD_RST_PTR_LOW);
        fw_master_inst.get(`TRD_OFS_PTR_HIGH, v);
        chk("ptr_high", v, 8'h00);
        fw_master_inst.get(`TRD_OFS_TRIGGER, v);
        chk("trigger", v, `TRD_RST_TRIGGER);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule : table_reader_tb
`default_nettype wire
